// ==== rtl/ags_axis_group_sm.sv ====
// axis and group operating-state machine with apb register access
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/1ps
module ags_axis_group_sm (
    input  wire logic                  clk_i,
    input  wire logic                  rst_n_i,
    input  wire ags_pkg::ags_apb_req_t apb_req_i,
    output ags_pkg::ags_apb_rsp_t      apb_rsp_o,
    output logic [3:0]                 axis_state_o,
    output logic [2:0]                 group_state_o,
    output logic                       command_aborted_flag_o,
    output logic                       axis_decel_o
);
    import ags_pkg::*;

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    logic          acc_w;
    logic          wr_w;
    logic [31:0]   axcmd_q;
    logic [31:0]   grcmd_q;
    logic          prev_en_q;
    logic          abort_q;
    logic          dec_q;
    logic [4:0]    memb_q;
    logic          ax_wr_w;
    logic          gr_wr_w;
    ags_axis_st_t  ax_q;
    ags_axis_st_t  ax_d;
    ags_group_st_t gr_q;
    ags_group_st_t gr_d;
    ags_apb_rsp_t  rsp_q;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction

    assign acc_w   = apb_req_i.psel && apb_req_i.penable;
    assign wr_w    = acc_w && apb_req_i.pwrite;
    assign ax_wr_w = wr_w && hit(apb_req_i.paddr, AGS_OFS_AXCMD);
    assign gr_wr_w = wr_w && hit(apb_req_i.paddr, AGS_OFS_GRCMD);

    // ------------------------------------------------------------------
    // command registers
    // ------------------------------------------------------------------
    // axis command word holds levels; pulse-type reset request self-clears
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            axcmd_q <= AGS_ZERO_WORD;
        end else if (ax_wr_w) begin
            axcmd_q <= apb_req_i.pwdata;
        end else begin
            axcmd_q[AGS_AX_RST_REQ] <= 1'b0;
        end
    end

    // group command bits are one-shot except stop execute/done and error
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            grcmd_q <= AGS_ZERO_WORD;
        end else if (gr_wr_w) begin
            grcmd_q <= apb_req_i.pwdata;
        end else begin
            grcmd_q[AGS_GR_MOVE]     <= 1'b0;
            grcmd_q[AGS_GR_RESET]    <= 1'b0;
            grcmd_q[AGS_GR_ADD]      <= 1'b0;
            grcmd_q[AGS_GR_REMOVE]   <= 1'b0;
            grcmd_q[AGS_GR_DISSOLVE] <= 1'b0;
            grcmd_q[AGS_GR_OFF]      <= 1'b0;
            grcmd_q[AGS_GR_DIS_OFF]  <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            prev_en_q <= 1'b0;
        end else begin
            prev_en_q <= axcmd_q[AGS_AX_PWR_EN];
        end
    end

    // ------------------------------------------------------------------
    // axis state
    // ------------------------------------------------------------------
    logic err_w, en_w, st_w, motion_ok_w;
    assign err_w = axcmd_q[AGS_AX_ERR];
    assign en_w  = axcmd_q[AGS_AX_PWR_EN];
    assign st_w  = axcmd_q[AGS_AX_PWR_ST];
    // motion only starts from standstill or an active motion state
    assign motion_ok_w = (ax_q == AGS_AX_STILL) || (ax_q == AGS_AX_CONTIN)
                      || (ax_q == AGS_AX_DISCRETE) || (ax_q == AGS_AX_SYNCED);

    always_comb begin
        ax_d = ax_q;
        if (err_w) begin
            ax_d = AGS_AX_FAULT;
        end else if (ax_q == AGS_AX_FAULT) begin
            // only the error reset leaves fault-halt
            if (axcmd_q[AGS_AX_RST_REQ]) begin
                if (!st_w) begin
                    ax_d = AGS_AX_OFF;
                end else if (en_w) begin
                    ax_d = AGS_AX_STILL;
                end
            end
        end else if (!en_w) begin
            ax_d = AGS_AX_OFF;
        end else if (ax_q == AGS_AX_OFF) begin
            if (en_w && !prev_en_q && st_w) begin
                ax_d = AGS_AX_STILL;
            end
        end else if (ax_q == AGS_AX_STOPPING) begin
            // power disable and error act at once; other commands wait until the stop block is done
            if (axcmd_q[AGS_AX_STOP_DN] && !axcmd_q[AGS_AX_STOP_EX]) begin
                ax_d = AGS_AX_STILL;
            end
        end else if (axcmd_q[AGS_AX_STOP_EX]) begin
            ax_d = AGS_AX_STOPPING;
        end else if (axcmd_q[AGS_AX_DONE]) begin
            ax_d = AGS_AX_STILL;
        end else if (axcmd_q[AGS_AX_HOME] && ax_q == AGS_AX_STILL) begin
            ax_d = AGS_AX_HOMING;
        end else if (motion_ok_w && axcmd_q[AGS_AX_SYNC]) begin
            ax_d = AGS_AX_SYNCED;
        end else if (motion_ok_w && axcmd_q[AGS_AX_CONT]) begin
            ax_d = AGS_AX_CONTIN;
        end else if (motion_ok_w && axcmd_q[AGS_AX_DISC]) begin
            ax_d = AGS_AX_DISCRETE;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ax_q <= AGS_AX_OFF;
        end else begin
            ax_q <= ax_d;
        end
    end

    // busy commands are cut when the axis drops to disabled
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            abort_q <= 1'b0;
        end else if (ax_d == AGS_AX_OFF && ax_q != AGS_AX_OFF
                     && ax_q != AGS_AX_STILL && ax_q != AGS_AX_FAULT) begin
            abort_q <= 1'b1;
        end else if (wr_w && hit(apb_req_i.paddr, AGS_OFS_ABORT)) begin
            abort_q <= 1'b0;
        end
    end

    // decel flag is high for as long as the axis is in fault, low once the fault clears
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            dec_q <= 1'b0;
        end else begin
            dec_q <= (ax_d == AGS_AX_FAULT);
        end
    end

    // ------------------------------------------------------------------
    // group state
    // ------------------------------------------------------------------
    logic       add_w, rem_w, dis_w;
    logic [4:0] memb_d;
    assign add_w = grcmd_q[AGS_GR_ADD];
    assign rem_w = grcmd_q[AGS_GR_REMOVE];
    assign dis_w = grcmd_q[AGS_GR_DISSOLVE];

    always_comb begin
        memb_d = memb_q;
        if (dis_w || grcmd_q[AGS_GR_DIS_OFF]) begin
            memb_d = AGS_MEMB_RESET;
        end else if (add_w && memb_q != 5'h1F) begin
            memb_d = memb_q + 5'h01;
        end else if (rem_w && memb_q != AGS_MEMB_RESET) begin
            memb_d = memb_q - 5'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            memb_q <= AGS_MEMB_RESET;
        end else begin
            memb_q <= memb_d;
        end
    end

    always_comb begin
        gr_d = gr_q;
        if (grcmd_q[AGS_GR_OFF] || grcmd_q[AGS_GR_DIS_OFF]) begin
            gr_d = AGS_GR_OFF_ST;
        end else if (grcmd_q[AGS_GR_ERR] && gr_q != AGS_GR_OFF_ST) begin
            gr_d = AGS_GR_FAULT_ST;
        end else begin
            unique case (gr_q)
                AGS_GR_OFF_ST: begin
                    if (add_w) begin
                        gr_d = AGS_GR_IDLE_ST;
                    end
                end
                AGS_GR_IDLE_ST, AGS_GR_MOTION: begin
                    if (grcmd_q[AGS_GR_STOP_EX]) begin
                        gr_d = AGS_GR_HALTING;
                    end else if (gr_q == AGS_GR_IDLE_ST
                                 && (rem_w || dis_w)
                                 && memb_d == AGS_MEMB_RESET) begin
                        gr_d = AGS_GR_OFF_ST;
                    end else if (gr_q == AGS_GR_IDLE_ST
                                 && (add_w || rem_w)) begin
                        gr_d = AGS_GR_IDLE_ST;
                    end else if (grcmd_q[AGS_GR_MOVE]) begin
                        gr_d = AGS_GR_MOTION;
                    end
                end
                AGS_GR_HALTING: begin
                    // motion commands are ignored here
                    if (grcmd_q[AGS_GR_STOP_DN]
                        && !grcmd_q[AGS_GR_STOP_EX]) begin
                        gr_d = AGS_GR_IDLE_ST;
                    end
                end
                AGS_GR_FAULT_ST: begin
                    if (grcmd_q[AGS_GR_RESET]) begin
                        gr_d = AGS_GR_IDLE_ST;
                    end
                end
                default: gr_d = AGS_GR_OFF_ST;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            gr_q <= AGS_GR_OFF_ST;
        end else begin
            gr_q <= gr_d;
        end
    end

    // ------------------------------------------------------------------
    // apb answer: zero wait states, unmapped reads zero with slverr
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rsp_q <= '0;
        end else begin
            rsp_q.pready  <= apb_req_i.psel && !apb_req_i.penable;
            rsp_q.pslverr <= apb_req_i.psel && !apb_req_i.penable
                && !(hit(apb_req_i.paddr, AGS_OFS_AXCMD)
                  || hit(apb_req_i.paddr, AGS_OFS_GRCMD)
                  || hit(apb_req_i.paddr, AGS_OFS_STATE)
                  || hit(apb_req_i.paddr, AGS_OFS_ABORT));
            rsp_q.prdata <= AGS_ZERO_WORD;
            if (apb_req_i.psel && !apb_req_i.penable
                && !apb_req_i.pwrite) begin
                if (hit(apb_req_i.paddr, AGS_OFS_AXCMD)) begin
                    rsp_q.prdata <= axcmd_q;
                end else if (hit(apb_req_i.paddr, AGS_OFS_GRCMD)) begin
                    rsp_q.prdata <= grcmd_q;
                end else if (hit(apb_req_i.paddr, AGS_OFS_STATE)) begin
                    // distinct state codes side by side
                    rsp_q.prdata <= {11'h000, memb_q, 5'h00, gr_q,
                                     4'h0, ax_q};
                end else if (hit(apb_req_i.paddr, AGS_OFS_ABORT)) begin
                    rsp_q.prdata <= {30'h0000_0000, dec_q, abort_q};
                end
            end
        end
    end

    assign apb_rsp_o              = rsp_q;
    assign axis_state_o           = ax_q;
    assign group_state_o          = gr_q;
    assign command_aborted_flag_o = abort_q;
    assign axis_decel_o           = dec_q;

endmodule

// ==== rtl/ags_pkg.sv ====
// package: states, command and status carriers for the axis/group state machine
package ags_pkg;

    // ------------------------------------------------------------------
    // register map (apb byte offsets)
    // ------------------------------------------------------------------
    localparam logic [7:0] AGS_OFS_AXCMD  = 8'h00;
    localparam logic [7:0] AGS_OFS_GRCMD  = 8'h04;
    localparam logic [7:0] AGS_OFS_STATE  = 8'h08;
    localparam logic [7:0] AGS_OFS_ABORT  = 8'h0C;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int AGS_AX_PWR_EN   = 0;
    localparam int AGS_AX_PWR_ST   = 1;
    localparam int AGS_AX_STOP_EX  = 2;
    localparam int AGS_AX_STOP_DN  = 3;
    localparam int AGS_AX_RST_REQ  = 4;
    localparam int AGS_AX_HOME     = 5;
    localparam int AGS_AX_CONT     = 6;
    localparam int AGS_AX_DISC     = 7;
    localparam int AGS_AX_SYNC     = 8;
    localparam int AGS_AX_DONE     = 9;
    localparam int AGS_AX_ERR      = 10;
    localparam int AGS_GR_MOVE     = 0;
    localparam int AGS_GR_STOP_EX  = 1;
    localparam int AGS_GR_STOP_DN  = 2;
    localparam int AGS_GR_RESET    = 3;
    localparam int AGS_GR_ADD      = 4;
    localparam int AGS_GR_REMOVE   = 5;
    localparam int AGS_GR_DISSOLVE = 6;
    localparam int AGS_GR_OFF      = 7;
    localparam int AGS_GR_DIS_OFF  = 8;
    localparam int AGS_GR_ERR      = 9;
    localparam int AGS_GR_CNT_LSB  = 16;
    localparam int AGS_ST_GR_LSB   = 8;

    localparam logic [31:0] AGS_ZERO_WORD  = 32'h0000_0000;
    localparam logic [4:0]  AGS_MEMB_RESET = 5'h00;

    // ------------------------------------------------------------------
    // states
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        AGS_AX_OFF      = 4'b0000,
        AGS_AX_STILL    = 4'b0001,
        AGS_AX_HOMING   = 4'b0010,
        AGS_AX_STOPPING = 4'b0011,
        AGS_AX_FAULT    = 4'b0100,
        AGS_AX_CONTIN   = 4'b0101,
        AGS_AX_DISCRETE = 4'b0110,
        AGS_AX_SYNCED   = 4'b0111
    } ags_axis_st_t;

    typedef enum logic [2:0] {
        AGS_GR_OFF_ST   = 3'b000,
        AGS_GR_IDLE_ST  = 3'b001,
        AGS_GR_MOTION   = 3'b010,
        AGS_GR_HALTING  = 3'b011,
        AGS_GR_FAULT_ST = 3'b100
    } ags_group_st_t;

    // ------------------------------------------------------------------
    // apb carrier
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } ags_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } ags_apb_rsp_t;

endpackage

// ==== testbench/ags_assertions.sv ====
// checker: concurrent properties on the state machine ports
`timescale 1ns/1ps
module ags_assertions
    import ags_pkg::*;
(
    input wire logic                  clk_i,
    input wire logic                  rst_n_i,
    input wire ags_pkg::ags_apb_req_t apb_req_i,
    input wire ags_pkg::ags_apb_rsp_t apb_rsp_o,
    input wire logic [3:0]            axis_state_o,
    input wire logic [2:0]            group_state_o,
    input wire logic                  command_aborted_flag_o,
    input wire logic                  axis_decel_o
);
    // ------------------------------------------------------------------
    // completed writes, seen at the edge they take effect
    // ------------------------------------------------------------------
    logic        acc;
    logic        wa;
    logic        wg;
    logic        flt;
    logic        stp;
    logic [31:0] d;
    assign acc = apb_req_i.psel && apb_req_i.penable && apb_rsp_o.pready;
    assign wa  = acc && apb_req_i.pwrite && apb_req_i.paddr == AGS_OFS_AXCMD;
    assign wg  = acc && apb_req_i.pwrite && apb_req_i.paddr == AGS_OFS_GRCMD;
    assign d   = apb_req_i.pwdata;
    assign flt = axis_state_o == AGS_AX_FAULT;
    assign stp = axis_state_o == AGS_AX_STOPPING;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // state follows the command register one clock late, hence ##2
    property p_start;
        $rose(rst_n_i) |-> !axis_state_o && !group_state_o;
    endproperty
    a_start: assert property (p_start) else $error("not off at start");
    property p_fault;
        wa && d[10] |-> ##2 flt;
    endproperty
    a_fault: assert property (p_fault) else $error("error missed");
    property p_decel;
        flt |-> axis_decel_o;
    endproperty
    a_decel: assert property (p_decel) else $error("no decel");
    property p_off;
        wa && !d[10] && !d[0] && !flt |-> ##2 axis_state_o == AGS_AX_OFF;
    endproperty
    a_off: assert property (p_off) else $error("not disabled");
    property p_keep;
        flt && wa && !d[4] |-> ##2 flt;
    endproperty
    a_keep: assert property (p_keep) else $error("left fault");
    property p_rst_ok;
        flt && wa && d[4] && d[1] && d[0] && !d[10] |-> ##2 axis_state_o == 1;
    endproperty
    a_rst_ok: assert property (p_rst_ok) else $error("no standstill");
    property p_rst_off;
        flt && wa && d[4] && !d[1] && !d[10] |-> ##2 axis_state_o == 0;
    endproperty
    a_rst_off: assert property (p_rst_off) else $error("no disable");
    property p_hold;
        stp && wa && d[0] && !d[3] && !d[10] |-> ##2 stp;
    endproperty
    a_hold: assert property (p_hold) else $error("stop left early");
    property p_stop_end;
        stp && wa && d[0] && d[3] && !d[2] && !d[10] |-> ##2 axis_state_o == 1;
    endproperty
    a_stop_end: assert property (p_stop_end) else $error("stop stuck");
    property p_gr_off;
        wg && (d[7] || d[8]) |-> ##2 group_state_o == AGS_GR_OFF_ST;
    endproperty
    a_gr_off: assert property (p_gr_off) else $error("group not off");
    property p_gr_halt;
        group_state_o == AGS_GR_HALTING && wg && d[9:0] == 10'h004
            |-> ##2 group_state_o == AGS_GR_IDLE_ST;
    endproperty
    a_gr_halt: assert property (p_gr_halt) else $error("halt stuck");
endmodule

// ==== testbench/ags_host_model.sv ====
// partner model: apb master standing for the host cpu program
`timescale 1ns/1ps
module ags_host_model
    import ags_pkg::*;
(
    input  wire logic                  clk_i,
    input  wire ags_pkg::ags_apb_rsp_t rsp_i,
    output ags_pkg::ags_apb_req_t      req_o
);
    initial req_o = '0;
    // waits on pready with no fixed latency; the bench timeout ends a hang
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] wd, output logic [31:0] rd,
                        output logic err);
        @(posedge clk_i);
        req_o.psel    <= 1'b1;
        req_o.penable <= 1'b0;
        req_o.pwrite  <= w;
        req_o.paddr   <= a;
        req_o.pwdata  <= wd;
        @(posedge clk_i);
        req_o.penable <= 1'b1;
        do @(posedge clk_i); while (rsp_i.pready !== 1'b1);
        rd = rsp_i.prdata;
        err = rsp_i.pslverr;
        req_o.psel    <= 1'b0;
        req_o.penable <= 1'b0;
    endtask
endmodule

// ==== testbench/tb.sv ====
// testbench: scenarios for the axis and group state machine
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin \
    fails++; $display("unexpected at %0t: %h vs %h", $time, a, e); end end
module tb;
    import ags_pkg::*;
    logic         clk_i;
    logic         rst_n_i;
    ags_apb_req_t req;
    ags_apb_rsp_t rsp;
    logic [3:0]   ax;
    logic [2:0]   gr;
    logic         ab;
    logic         dc;
    logic [31:0]  rd;
    logic         er;
    int           fails;
    int           total_checks;
    int           cyc;
    ags_axis_group_sm ags_axis_group_sm_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .apb_req_i(req), .apb_rsp_o(rsp), .axis_state_o(ax),
        .group_state_o(gr), .command_aborted_flag_o(ab), .axis_decel_o(dc));
    ags_host_model ags_host_model_i (.clk_i(clk_i), .rsp_i(rsp), .req_o(req));
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    // ------------------------------------------------------------------
    // bus helpers
    // ------------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ags_host_model_i.xfer(1'b1, a, d, rd, er);
    endtask
    task automatic rdr(input logic [7:0] a);
        ags_host_model_i.xfer(1'b0, a, 32'h0, rd, er);
    endtask
    // state lags the register write by one clock
    task automatic wa(input logic [31:0] d, input logic [3:0] e);
        wr(AGS_OFS_AXCMD, d);
        @(posedge clk_i);
        #1;
        `CHK(ax, e)
    endtask
    task automatic wg(input logic [31:0] d, input logic [2:0] e);
        wr(AGS_OFS_GRCMD, d);
        @(posedge clk_i);
        #1;
        `CHK(gr, e)
    endtask
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        `CHK({ax, gr, ab, dc}, 9'h000)
        rdr(AGS_OFS_STATE);
        `CHK(rd, 32'h0000_0000)
    endtask
    task automatic t_power();
        wa(32'h0000_0003, AGS_AX_STILL);
        rdr(AGS_OFS_STATE);
        `CHK(rd[3:0], 4'h1)
        wa(32'h0000_0023, AGS_AX_HOMING);
        wa(32'h0000_0020, AGS_AX_OFF);
        `CHK(ab, 1'b1)
        rdr(AGS_OFS_ABORT);
        `CHK(rd[0], 1'b1)
        wr(AGS_OFS_ABORT, 32'h0000_0000);
        @(posedge clk_i);
        #1;
        `CHK(ab, 1'b0)
    endtask
    task automatic t_stop();
        wa(32'h0000_0003, AGS_AX_STILL);
        wa(32'h0000_0007, AGS_AX_STOPPING);
        wa(32'h0000_0047, AGS_AX_STOPPING);
        wa(32'h0000_000B, AGS_AX_STILL);
    endtask
    // every motion state, left by done and a power drop; stop entered from standstill
    task automatic t_motion();
        wa(32'h0000_0043, AGS_AX_CONTIN);
        wa(32'h0000_0083, AGS_AX_DISCRETE);
        wa(32'h0000_0103, AGS_AX_SYNCED);
        wa(32'h0000_0203, AGS_AX_STILL);
        wa(32'h0000_0047, AGS_AX_STOPPING);
        wa(32'h0000_004B, AGS_AX_STILL);
        wa(32'h0000_0043, AGS_AX_CONTIN);
        wa(32'h0000_0042, AGS_AX_OFF);
        `CHK(ab, 1'b1)
        wr(AGS_OFS_ABORT, 32'h0000_0000);
        @(posedge clk_i);
        #1;
        `CHK(ab, 1'b0)
    endtask
    task automatic t_fault();
        wa(32'h0000_0407, AGS_AX_FAULT);
        `CHK(dc, 1'b1)
        wa(32'h0000_0402, AGS_AX_FAULT);
        wa(32'h0000_0403, AGS_AX_FAULT);
        wa(32'h0000_0043, AGS_AX_FAULT);
        wa(32'h0000_0013, AGS_AX_STILL);
        `CHK(dc, 1'b0)
        wa(32'h0000_0401, AGS_AX_FAULT);
        wa(32'h0000_0011, AGS_AX_OFF);
    endtask
    task automatic t_group();
        wg(32'h0000_0010, AGS_GR_IDLE_ST);
        wg(32'h0000_0001, AGS_GR_MOTION);
        rdr(AGS_OFS_STATE);
        `CHK(rd[10:8], 3'h2)
        wg(32'h0000_0002, AGS_GR_HALTING);
        wg(32'h0000_0003, AGS_GR_HALTING);
        wg(32'h0000_0004, AGS_GR_IDLE_ST);
        wg(32'h0000_0200, AGS_GR_FAULT_ST);
        wg(32'h0000_0201, AGS_GR_FAULT_ST);
        wg(32'h0000_0008, AGS_GR_IDLE_ST);
        wg(32'h0000_0010, AGS_GR_IDLE_ST);
        rdr(AGS_OFS_STATE);
        `CHK(rd[20:16], 5'h02)
        wg(32'h0000_0020, AGS_GR_IDLE_ST);
        wg(32'h0000_0020, AGS_GR_OFF_ST);
        wg(32'h0000_0010, AGS_GR_IDLE_ST);
        wg(32'h0000_0040, AGS_GR_OFF_ST);
        wg(32'h0000_0010, AGS_GR_IDLE_ST);
        wg(32'h0000_0001, AGS_GR_MOTION);
        wg(32'h0000_0080, AGS_GR_OFF_ST);
        wg(32'h0000_0010, AGS_GR_IDLE_ST);
        wg(32'h0000_0100, AGS_GR_OFF_ST);
    endtask
    task automatic t_bus();
        rdr(8'h10);
        `CHK({er, rd}, 33'h1_0000_0000)
        // enable must be seen low before it can rise again
        wa(32'h0000_0002, AGS_AX_OFF);
        wa(32'h0000_0003, AGS_AX_STILL);
        wr(8'h10, 32'hFFFF_FFFF);
        @(posedge clk_i);
        #1;
        `CHK(ax, AGS_AX_STILL)
    endtask
    task automatic end_of_test();
        if (fails == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // limit well above the few hundred cycles the scenarios need
    always @(posedge clk_i) begin
        cyc++;
        if (cyc > 5000) begin
            fails++;
            end_of_test();
        end
    end
    initial begin
        rst_n_i = 1'b0;
        repeat (10) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        #1;
        t_reset();
        t_power();
        t_stop();
        t_motion();
        t_fault();
        t_group();
        t_bus();
        end_of_test();
    end
endmodule
bind ags_axis_group_sm ags_assertions ags_assertions_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .apb_req_i(apb_req_i),
    .apb_rsp_o(apb_rsp_o), .axis_state_o(axis_state_o),
    .group_state_o(group_state_o),
    .command_aborted_flag_o(command_aborted_flag_o),
    .axis_decel_o(axis_decel_o));
